//--- tmon_i2c_master_model.sv
`timescale 1ns/10ps
module tmon_i2c_master_model (
	// clock
	input  wire logic ref_clk,
	// bus pins
	input  wire logic sdaLine,
	output logic      sclOut,
	output logic      sdaLow
);
	initial begin
		sclOut = 1'b1;
		sdaLow = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////
	// quarter bit; each scl phase stays far above the pin synchronisers
	task automatic qtr();
		repeat (12) @(posedge ref_clk);
		#1;
	endtask
	task automatic start_cond();
		sdaLow = 1'b0;
		qtr();
		sclOut = 1'b1;
		qtr();
		sdaLow = 1'b1;
		qtr();
		sclOut = 1'b0;
		qtr();
	endtask
	task automatic stop_cond();
		sdaLow = 1'b1;
		qtr();
		sclOut = 1'b1;
		qtr();
		sdaLow = 1'b0;
		qtr();
	endtask
	task automatic bitx(input logic b, output logic r);
		sdaLow = ~b;
		qtr();
		sclOut = 1'b1;
		qtr();
		r = sdaLine;
		qtr();
		sclOut = 1'b0;
		qtr();
	endtask
	// last = 1 releases the ninth bit (nack on reads)
	task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
			output logic nak);
		for (int i = 7; i >= 0; i--) begin
			bitx(d[i], q[i]);
		end
		bitx(last, nak);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [15:0] v,
			input logic two, output logic nak);
		logic [7:0] q;
		logic       k0, k1, k2, k3;
		k3 = 1'b0;
		start_cond();
		xbyte({a, 1'b0}, 1'b1, q, k0);
		xbyte(p, 1'b1, q, k1);
		xbyte(v[15:8], 1'b1, q, k2);
		if (two) begin
			xbyte(v[7:0], 1'b1, q, k3);
		end
		stop_cond();
		nak = k0 | k1 | k2 | k3;
	endtask
	task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [15:0] v,
			output logic nak);
		logic [7:0] q;
		logic       k0, k1, k2, k3;
		start_cond();
		xbyte({a, 1'b0}, 1'b1, q, k0);
		xbyte(p, 1'b1, q, k1);
		start_cond();
		xbyte({a, 1'b1}, 1'b1, q, k2);
		xbyte(8'hFF, 1'b0, v[15:8], k3);
		xbyte(8'hFF, 1'b1, v[7:0], k3);
		stop_cond();
		nak = k0 | k1 | k2;
	endtask
	// holds scl low after the address ack, then sends one pointer byte
	task automatic stall_ptr(input logic [6:0] a, input logic [7:0] p, input int n,
			output logic nak);
		logic [7:0] q;
		logic       k0;
		start_cond();
		xbyte({a, 1'b0}, 1'b1, q, k0);
		repeat (n) @(posedge ref_clk);
		#1;
		xbyte(p, 1'b1, q, nak);
		stop_cond();
	endtask
endmodule

//--- tmon_i2c_slave.sv
`timescale 1ns/10ps
module tmon_i2c_slave #(
	parameter int TIMEOUT_CYCLES_P = tmon_pkg::TIMEOUT_CYCLES
) (
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          reset,
	// bus pins
	input  wire logic          sclIn,
	input  wire logic          sdaIn,
	output logic               sdaOut,
	output logic               sdaOe,
	input  wire logic [3:0]    addrStraps,
	// control
	input  wire logic          timeoutOff,
	// register side
	output tmon_pkg::tmon_rx_t rxEvt,
	output logic               startPulse,
	output logic               txLoad,
	input  wire logic [7:0]    txData
);
	import tmon_pkg::*;

	localparam int TW = $clog2(TIMEOUT_CYCLES_P + 1);

	logic [1:0]      sclSync_r;
	logic [1:0]      sdaSync_r;
	logic [3:0]      strapMeta_r;
	logic [3:0]      strap_r;
	logic            sclPrev_r;
	logic            sdaPrev_r;
	tmon_bus_state_t state_r;
	logic [3:0]      bitCnt_r;
	logic [7:0]      shift_r;
	logic [7:0]      txShift_r;
	logic            rnw_r;
	logic            firstByte_r;
	logic [TW-1:0]   lowCnt_r;

	////////////////////////////////////////////////////////////////
	wire logic sclHi     = sclSync_r[1];
	wire logic sdaHi     = sdaSync_r[1];
	wire logic sclRise   = sclHi & ~sclPrev_r;
	wire logic sclFall   = ~sclHi & sclPrev_r;
	wire logic startSeen = sclHi & sclPrev_r & sdaPrev_r & ~sdaHi;
	wire logic stopSeen  = sclHi & sclPrev_r & ~sdaPrev_r & sdaHi;
	wire logic timedOut  = ~timeoutOff & (state_r != BUS_IDLE) & (lowCnt_r == TW'(TIMEOUT_CYCLES_P));
	wire logic advance   = ~startSeen & ~stopSeen & ~timedOut;
	wire logic byteDone  = sclFall & (bitCnt_r == 4'h8);
	wire logic addrMatch = shift_r[7:1] == {ADDR_FIXED, strap_r};
	wire logic masterAck = ~shift_r[0];

	assign startPulse  = startSeen;
	assign rxEvt.valid = advance & (state_r == BUS_WRITE) & byteDone;
	assign rxEvt.first = firstByte_r;
	assign rxEvt.data  = shift_r;
	assign txLoad      = advance & sclFall & (((state_r == BUS_ACK_ADDR) & rnw_r)
		| ((state_r == BUS_ACK_RD) & masterAck));
	// open drain: only ever pulls low
	assign sdaOut      = 1'h0;
	assign sdaOe       = (state_r == BUS_ACK_ADDR) | (state_r == BUS_ACK_WR)
		| ((state_r == BUS_READ) & ~txShift_r[7]);

	////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk) begin
		sclSync_r   <= {sclSync_r[0], sclIn};
		sdaSync_r   <= {sdaSync_r[0], sdaIn};
		strapMeta_r <= addrStraps;
		strap_r     <= strapMeta_r;
		sclPrev_r   <= sclHi;
		sdaPrev_r   <= sdaHi;
	end

	// scl held low mid-frame; cleared whenever the line is high or idle
	always_ff @(posedge ref_clk) begin
		if (reset || sclHi || state_r == BUS_IDLE) begin
			lowCnt_r <= '0;
		end else if (lowCnt_r != TW'(TIMEOUT_CYCLES_P)) begin
			lowCnt_r <= lowCnt_r + TW'(1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_r     <= BUS_IDLE;
			bitCnt_r    <= 4'h0;
			shift_r     <= 8'h00;
			txShift_r   <= 8'hFF;
			rnw_r       <= 1'h0;
			firstByte_r <= 1'h0;
		end else if (startSeen) begin
			state_r  <= BUS_ADDR;
			bitCnt_r <= 4'h0;
		end else if (!advance) begin
			state_r <= BUS_IDLE;
		end else begin
			if (sclRise) begin
				shift_r  <= {shift_r[6:0], sdaHi};
				bitCnt_r <= bitCnt_r + 4'h1;
			end
			case (state_r)
				BUS_ADDR: if (byteDone) begin
					rnw_r   <= shift_r[0];
					state_r <= addrMatch ? BUS_ACK_ADDR : BUS_IDLE;
				end
				BUS_ACK_ADDR: if (sclFall) begin
					bitCnt_r    <= 4'h0;
					firstByte_r <= 1'h1;
					txShift_r   <= txData;
					state_r     <= rnw_r ? BUS_READ : BUS_WRITE;
				end
				BUS_WRITE: if (byteDone) begin
					state_r <= BUS_ACK_WR;
				end
				BUS_ACK_WR: if (sclFall) begin
					bitCnt_r    <= 4'h0;
					firstByte_r <= 1'h0;
					state_r     <= BUS_WRITE;
				end
				BUS_READ: if (byteDone) begin
					state_r <= BUS_ACK_RD;
				end else if (sclFall) begin
					txShift_r <= {txShift_r[6:0], 1'h1};
				end
				BUS_ACK_RD: if (sclFall) begin
					bitCnt_r  <= 4'h0;
					txShift_r <= txData;
					state_r   <= masterAck ? BUS_READ : BUS_IDLE;
				end
				default: state_r <= BUS_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	property p_addr_match;
		@(posedge ref_clk) disable iff (reset)
		(state_r == BUS_ADDR && byteDone && advance) |=> ((state_r == BUS_ACK_ADDR)
			== ($past(shift_r[7:5]) == 3'h4 && $past(shift_r[4:1]) == $past(strap_r)));
	endproperty
	a_addr_match: assert property (p_addr_match) else $error("address decode wrong");

	// scl low and no falling edge: only the timeout could idle the slave here
	property p_timeout_off;
		@(posedge ref_clk) disable iff (reset)
		(timeoutOff && state_r != BUS_IDLE && !sclHi && !sclFall) |=> state_r != BUS_IDLE;
	endproperty
	a_timeout_off: assert property (p_timeout_off) else $error("timeout fired while disabled");

	property p_timeout_on;
		@(posedge ref_clk) disable iff (reset)
		(!timeoutOff && state_r != BUS_IDLE && lowCnt_r == TW'(TIMEOUT_CYCLES_P) && !startSeen)
			|=> state_r == BUS_IDLE;
	endproperty
	a_timeout_on: assert property (p_timeout_on) else $error("timeout did not idle the slave");
endmodule

//--- tmon_pkg.sv
package tmon_pkg;
	// register pointers
	localparam logic [7:0] PTR_TEMP = 8'h00;
	localparam logic [7:0] PTR_CFG  = 8'h01;
	localparam logic [7:0] PTR_HYST = 8'h02;
	localparam logic [7:0] PTR_CRIT = 8'h03;
	localparam logic [7:0] PTR_LOW  = 8'h04;
	localparam logic [7:0] PTR_HIGH = 8'h05;
	// power-on values
	localparam logic [15:0] RST_TEMP = 16'h0000;
	localparam logic [7:0]  RST_CFG  = 8'h00;
	localparam logic [15:0] RST_HYST = 16'h0100;
	localparam logic [15:0] RST_CRIT = 16'h2800;
	localparam logic [15:0] RST_LOW  = 16'h0500;
	localparam logic [15:0] RST_HIGH = 16'h2000;
	// config byte fields
	localparam int CFG_SHUTDOWN    = 0;
	localparam int CFG_INT_MODE    = 1;
	localparam int CFG_CRIT_POL    = 2;
	localparam int CFG_ALERT_POL   = 3;
	localparam int CFG_QUEUE4      = 4;
	localparam int CFG_TIMEOUT_OFF = 5;
	// reading and limit layouts
	localparam int TEMP_LSB  = 3;
	localparam int LIM_LSB   = 7;
	localparam int FLAG_CRIT = 2;
	localparam int FLAG_HIGH = 1;
	localparam int FLAG_LOW  = 0;
	// slave address upper bits, low four bits from the straps
	localparam logic [2:0] ADDR_FIXED = 3'h4;
	// fault queue depths
	localparam logic [2:0] QUEUE_SHORT = 3'h1;
	localparam logic [2:0] QUEUE_LONG  = 3'h4;
	// timing
	localparam int CLK_HZ         = 100_000_000;
	localparam int CONV_MS        = 500;
	localparam int CONV_CYCLES    = CONV_MS * (CLK_HZ / 1000);
	localparam int TIMEOUT_MS     = 25;
	localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);

	typedef enum logic [2:0] {
		BUS_IDLE     = 3'b000,
		BUS_ADDR     = 3'b001,
		BUS_ACK_ADDR = 3'b010,
		BUS_WRITE    = 3'b011,
		BUS_ACK_WR   = 3'b100,
		BUS_READ     = 3'b101,
		BUS_ACK_RD   = 3'b110
	} tmon_bus_state_t;

	typedef struct packed {
		logic       valid;
		logic       first;
		logic [7:0] data;
	} tmon_rx_t;

	typedef struct packed {
		logic        valid;
		logic [12:0] value;
	} tmon_sample_t;
endpackage

//--- tmon_register_file.sv
`timescale 1ns/10ps
// What this block does
// - Answer slave address 100 followed by the four strap levels.
// - Pointer 00h..05h selects temperature, config, hysteresis, critical, lower, upper.
// - Power-on values: 0000h, 00h, 0100h, 2800h, 0500h, 2000h.
// - Temperature bits 15..3 hold two's-complement sixteenths of a degree.
// - Temperature bits 2,1,0 flag critical, upper and lower conditions.
// - Encodings like 0C80h for +25 and FFF8h for -0.0625 hold, flags ignored.
// - Config bit 0 set places the device in shutdown.
// - Config bit 1 picks comparator (0) or interrupt (1) alarm behaviour.
// - Config bits 2 and 3 set critical and alarm output polarity, 1 high.
// - Config bit 5 set disables the bus timeout.
// - Config bit 4 picks a fault queue depth of one or four.
// - Limit registers hold signed whole degrees in bits 15..7.
// - Limit bits 6..0 read zero and ignore writes.
// - Interrupt alarm stays asserted until any register is read outside shutdown.
// - Comparator alarm clears after queue-depth conversions inside limits with hysteresis.
// - Shutdown freezes both alarm outputs and holds the fault queue cleared.
// - Conversion every 500 ms; reading temperature aborts the running one.
module tmon_register_file #(
	parameter int CONV_CYCLES_P    = tmon_pkg::CONV_CYCLES,
	parameter int TIMEOUT_CYCLES_P = tmon_pkg::TIMEOUT_CYCLES
) (
	// clocks and reset
	input  wire logic             ref_clk,
	input  wire logic             reset,
	input  wire logic             adc_clk,
	// converter results, adc_clk domain
	input  tmon_pkg::tmon_sample_t adcSample,
	// serial bus
	input  wire logic             sclIn,
	input  wire logic             sdaIn,
	output logic                  sdaOut,
	output logic                  sdaOe,
	input  wire logic [3:0]       addrStraps,
	// alarm pins
	output logic                  alertOut,
	output logic                  criticalHeatOut
);
	import tmon_pkg::*;

	localparam int CW = $clog2(CONV_CYCLES_P + 1);
	localparam logic [3:0][15:0] RST_LIMITS = {RST_HIGH, RST_LOW, RST_CRIT, RST_HYST};

	tmon_rx_t    rxEvt;
	logic        startPulse;
	logic        txLoad;
	logic [7:0]  txData;
	logic [7:0]  cfg_r;
	logic [15:0] temp_r;
	logic [8:0]  lim_r [4];
	logic [7:0]  pointer_r;
	logic        byteIdx_r;
	logic [7:0]  msbHold_r;
	logic [12:0] latest_r;
	logic [CW-1:0] convTimer_r;
	logic        alertInt_r;
	logic [1:0]  chOn;
	logic [1:0]  chFlip;
	logic [1:0]  chFault;
	logic [1:0]  chClear;

	////////////////////////////////////////////////////////////////
	// converter domain: hold word until the ref side acknowledges
	logic [1:0]  adcRst_r;
	logic [12:0] adcHold_r;
	logic        reqTog_r;
	logic [1:0]  ackSync_r;
	logic [1:0]  reqSync_r;
	logic        ackTog_r;
	wire logic   adcReset = adcRst_r[1];
	wire logic   adcBusy  = reqTog_r ^ ackSync_r[1];

	always_ff @(posedge adc_clk) begin
		adcRst_r  <= {adcRst_r[0], reset};
		ackSync_r <= {ackSync_r[0], ackTog_r};
	end

	always_ff @(posedge adc_clk) begin
		if (adcReset) begin
			adcHold_r <= 13'h0000;
			reqTog_r  <= 1'h0;
		end else if (adcSample.valid && !adcBusy) begin
			adcHold_r <= adcSample.value;
			reqTog_r  <= ~reqTog_r;
		end
	end

	// hold word is stable while the toggle differs, so a plain capture is safe
	wire logic newSample = reqSync_r[1] ^ ackTog_r;

	always_ff @(posedge ref_clk) begin
		reqSync_r <= {reqSync_r[0], reqTog_r};
		if (reset) begin
			ackTog_r <= 1'h0;
			latest_r <= 13'h0000;
		end else if (newSample) begin
			ackTog_r <= reqSync_r[1];
			latest_r <= adcHold_r;
		end
	end

	////////////////////////////////////////////////////////////////
	tmon_i2c_slave #(
		.TIMEOUT_CYCLES_P (TIMEOUT_CYCLES_P)
	) u_slave (
		.ref_clk    (ref_clk),
		.reset      (reset),
		.sclIn      (sclIn),
		.sdaIn      (sdaIn),
		.sdaOut     (sdaOut),
		.sdaOe      (sdaOe),
		.addrStraps (addrStraps),
		.timeoutOff (cfg_r[CFG_TIMEOUT_OFF]),
		.rxEvt      (rxEvt),
		.startPulse (startPulse),
		.txLoad     (txLoad),
		.txData     (txData)
	);

	////////////////////////////////////////////////////////////////
	wire logic       shutdown  = cfg_r[CFG_SHUTDOWN];
	wire logic       intMode   = cfg_r[CFG_INT_MODE];
	wire logic       regWrite  = rxEvt.valid & ~rxEvt.first;
	wire logic       ptrIsLim  = (pointer_r >= PTR_HYST) && (pointer_r <= PTR_HIGH);
	wire logic [7:0] limOff    = pointer_r - PTR_HYST;
	wire logic [1:0] limIdx    = limOff[1:0];
	wire logic       tempRead  = txLoad & (pointer_r == PTR_TEMP);
	wire logic [2:0] depth     = cfg_r[CFG_QUEUE4] ? QUEUE_LONG : QUEUE_SHORT;
	wire logic       convDone  = ~shutdown & (convTimer_r == CW'(CONV_CYCLES_P - 1));
	wire logic [15:0] selWord  = (pointer_r == PTR_TEMP) ? temp_r
		: (pointer_r == PTR_CFG) ? {cfg_r, cfg_r}
		: ptrIsLim ? {lim_r[limIdx], 7'h00}
		: 16'h0000;

	assign txData = byteIdx_r ? selWord[7:0] : selWord[15:8];

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pointer_r <= 8'h00;
			byteIdx_r <= 1'h0;
			msbHold_r <= 8'h00;
		end else if (startPulse || (rxEvt.valid && rxEvt.first)) begin
			if (rxEvt.valid) begin
				pointer_r <= rxEvt.data;
			end
			byteIdx_r <= 1'h0;
		end else if (regWrite || txLoad) begin
			byteIdx_r <= ~byteIdx_r;
			if (regWrite && !byteIdx_r) begin
				msbHold_r <= rxEvt.data;
			end
		end
	end

	// reserved bits are stored as written; software keeps them zero
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cfg_r <= RST_CFG;
		end else if (regWrite && !byteIdx_r && pointer_r == PTR_CFG) begin
			cfg_r <= rxEvt.data;
		end
	end

	for (genvar e = 0; e < 4; e++) begin : g_lim
		always_ff @(posedge ref_clk) begin
			if (reset) begin
				lim_r[e] <= RST_LIMITS[e][15:LIM_LSB];
			end else if (regWrite && byteIdx_r && ptrIsLim && limIdx == 2'(e)) begin
				lim_r[e] <= {msbHold_r, rxEvt.data[7]};
			end
		end
	end

	// a temperature read restarts the period rather than pausing it
	always_ff @(posedge ref_clk) begin
		if (reset || shutdown || tempRead || convDone) begin
			convTimer_r <= '0;
		end else begin
			convTimer_r <= convTimer_r + CW'(1);
		end
	end

	////////////////////////////////////////////////////////////////
	// compare in sixteenths; two spare bits keep limit plus hysteresis from wrapping
	function automatic logic signed [14:0] toQ(input logic [8:0] deg);
		return {{2{deg[8]}}, deg, 4'h0};
	endfunction

	wire logic signed [14:0] tQ    = {{2{latest_r[12]}}, latest_r};
	wire logic signed [14:0] hystQ = toQ(lim_r[0]);
	wire logic signed [14:0] critQ = toQ(lim_r[1]);
	wire logic signed [14:0] lowQ  = toQ(lim_r[2]);
	wire logic signed [14:0] highQ = toQ(lim_r[3]);
	wire logic signed [14:0] hiRel = highQ - hystQ;
	wire logic signed [14:0] loRel = lowQ + hystQ;
	wire logic               hiFault   = tQ > highQ;
	wire logic               loFault   = tQ < lowQ;
	wire logic               critFault = tQ > critQ;

	assign chFault = {critFault, hiFault | loFault};
	assign chClear = {tQ < (critQ - hystQ), (tQ < hiRel) & (tQ > loRel)};

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			temp_r <= RST_TEMP;
		end else if (convDone) begin
			temp_r <= {latest_r, critFault, hiFault, loFault};
		end
	end

	// channel 0 drives the general alarm, channel 1 the critical output
	for (genvar c = 0; c < 2; c++) begin : g_chan
		logic [2:0] qCnt_r;
		logic       on_r;
		wire logic  hit  = on_r ? chClear[c] : chFault[c];
		// at least, so a depth cut mid-count cannot leave the queue unreachable
		wire logic  full = (qCnt_r + 3'h1) >= depth;
		assign chOn[c]   = on_r;
		assign chFlip[c] = convDone & hit & full;
		always_ff @(posedge ref_clk) begin
			if (reset) begin
				qCnt_r <= 3'h0;
				on_r   <= 1'h0;
			end else if (shutdown) begin
				qCnt_r <= 3'h0;
			end else if (convDone) begin
				qCnt_r <= (hit && !full) ? qCnt_r + 3'h1 : 3'h0;
				if (hit && full) begin
					on_r <= ~on_r;
				end
			end
		end
	end

	// any channel 0 crossing latches; a read outside shutdown clears, but a crossing in that cycle wins
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			alertInt_r <= 1'h0;
		end else if (chFlip[0]) begin
			alertInt_r <= 1'h1;
		end else if (txLoad && !shutdown) begin
			alertInt_r <= 1'h0;
		end
	end

	wire logic alertState = intMode ? alertInt_r : chOn[0];

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			alertOut        <= 1'h1;
			criticalHeatOut <= 1'h1;
		end else if (!shutdown) begin
			alertOut        <= cfg_r[CFG_ALERT_POL] ? alertState : ~alertState;
			criticalHeatOut <= cfg_r[CFG_CRIT_POL] ? chOn[1] : ~chOn[1];
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	property p_por;
		$past(reset) |-> cfg_r == 8'h00 && temp_r == 16'h0000 && lim_r[0] == 9'h002
			&& lim_r[1] == 9'h050 && lim_r[2] == 9'h00A && lim_r[3] == 9'h040;
	endproperty
	a_por: assert property (p_por) else $error("power-on value wrong");

	property p_ptr;
		rxEvt.valid && rxEvt.first |=> pointer_r == $past(rxEvt.data) && !byteIdx_r;
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer not taken");

	property p_cfg_read;
		txLoad && !byteIdx_r && pointer_r == 8'h01 |-> txData == cfg_r;
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");

	property p_lim_low;
		txLoad && byteIdx_r && ptrIsLim |-> txData[6:0] == 7'h00;
	endproperty
	a_lim_low: assert property (p_lim_low) else $error("limit low bits not zero");

	property p_temp_ro;
		regWrite && pointer_r == 8'h00 && !convDone |=> $stable(temp_r);
	endproperty
	a_temp_ro: assert property (p_temp_ro) else $error("temperature was written");

	property p_reading;
		convDone |=> temp_r[15:3] == $past(latest_r)
			&& temp_r[2:0] == {$past(critFault), $past(hiFault), $past(loFault)};
	endproperty
	a_reading: assert property (p_reading) else $error("reading or flags wrong");

	property p_abort;
		tempRead ##1 !tempRead |-> convTimer_r <= 1;
	endproperty
	a_abort: assert property (p_abort) else $error("conversion not aborted");

	property p_queue1;
		convDone && !cfg_r[4] && !chOn[1] && critFault |=> chOn[1];
	endproperty
	a_queue1: assert property (p_queue1) else $error("depth one not honoured");

	property p_comp_clear;
		convDone && !cfg_r[4] && chOn[0] && chClear[0] |=> !chOn[0];
	endproperty
	a_comp_clear: assert property (p_comp_clear) else $error("comparator did not clear");

	property p_int_read;
		intMode && !shutdown && txLoad && !chFlip[0] |=> !alertInt_r;
	endproperty
	a_int_read: assert property (p_int_read) else $error("read did not clear alarm");

	property p_freeze;
		shutdown && $past(shutdown) |=> $stable(alertOut) && $stable(criticalHeatOut);
	endproperty
	a_freeze: assert property (p_freeze) else $error("outputs moved in shutdown");

	property p_polarity;
		!shutdown |=> alertOut == ($past(cfg_r[3]) ? $past(alertState) : !$past(alertState));
	endproperty
	a_polarity: assert property (p_polarity) else $error("alarm polarity wrong");
endmodule

//--- tmon_register_file_tb.sv
`timescale 1ns/10ps
module tmon_register_file_tb;
	import tmon_pkg::*;
	localparam logic [6:0] DEV_ADDR = 7'h4A;
	// clocks and reset
	logic         ref_clk;
	logic         adc_clk;
	logic         reset;
	// pins
	logic         sclLine;
	logic         sdaLow;
	logic         sdaLine;
	logic         sdaOut;
	logic         sdaOe;
	logic         alertOut;
	logic         criticalHeatOut;
	logic [15:0]  pinView;
	tmon_sample_t adcSample;
	logic [3:0]   straps;
	int           errors = 0;
	int           total_checks = 0;
	// pull-up on the open-drain data line
	assign sdaLine = ~((sdaOe & ~sdaOut) | sdaLow);
	assign pinView = {14'h0000, alertOut, criticalHeatOut};
	tmon_register_file #(
		.CONV_CYCLES_P   (200),
		.TIMEOUT_CYCLES_P(5000)
	) u_tmon_register_file (
		.ref_clk        (ref_clk),
		.reset          (reset),
		.adc_clk        (adc_clk),
		.adcSample      (adcSample),
		.sclIn          (sclLine),
		.sdaIn          (sdaLine),
		.sdaOut         (sdaOut),
		.sdaOe          (sdaOe),
		.addrStraps     (straps),
		.alertOut       (alertOut),
		.criticalHeatOut(criticalHeatOut)
	);
	tmon_i2c_master_model u_tmon_i2c_master_model (
		.ref_clk(ref_clk),
		.sdaLine(sdaLine),
		.sclOut (sclLine),
		.sdaLow (sdaLow)
	);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		adc_clk = 1'b0;
		#3.7;
		forever #15 adc_clk = ~adc_clk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic send_temp(input logic [12:0] t);
		@(posedge adc_clk);
		#1;
		adcSample = '{valid: 1'b1, value: t};
		@(posedge adc_clk);
		#1;
		adcSample.valid = 1'b0;
	endtask
	task automatic wr(input logic [7:0] p, input logic [15:0] v);
		logic nak;
		u_tmon_i2c_master_model.write_reg(DEV_ADDR, p, v, 1'b1, nak);
		check({15'h0000, nak}, 16'h0000);
	endtask
	// reserved bits always go out as zero
	task automatic wr_cfg(input logic [7:0] c);
		logic nak;
		u_tmon_i2c_master_model.write_reg(DEV_ADDR, PTR_CFG, {2'b00, c[5:0], 8'h00}, 1'b0, nak);
		check({15'h0000, nak}, 16'h0000);
	endtask
	task automatic rd(input logic [7:0] p, output logic [15:0] v);
		logic nak;
		u_tmon_i2c_master_model.read_reg(DEV_ADDR, p, v, nak);
		check({15'h0000, nak}, 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic scen_reset();
		logic [7:0]  ptrs [5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05};
		logic [15:0] exps [5] = '{16'h0000, 16'h0100, 16'h2800, 16'h0500, 16'h2000};
		logic [15:0] v;
		check(pinView, 16'h0003);
		foreach (ptrs[i]) begin
			rd(ptrs[i], v);
			check(v, exps[i]);
		end
	endtask
	task automatic scen_bus();
		logic [15:0] v;
		logic        nak;
		u_tmon_i2c_master_model.write_reg(DEV_ADDR ^ 7'h01, PTR_HYST, 16'h0500, 1'b1, nak);
		check({15'h0000, nak}, 16'h0001);
		straps = 4'h5;
		cyc(3);
		u_tmon_i2c_master_model.read_reg(7'h45, PTR_HYST, v, nak);
		check({15'h0000, nak}, 16'h0000);
		check(v, 16'h0100);
		straps = 4'hA;
		cyc(3);
		rd(8'h06, v);
		check(v, 16'h0000);
		wr(PTR_HYST, 16'h03FF);
		rd(PTR_HYST, v);
		check(v, 16'h0380);
	endtask
	task automatic scen_encode();
		logic [12:0] vals [4] = '{13'h1C8E, 13'h07D0, 13'h1FFF, 13'h0190};
		logic [15:0] exps [4] = '{16'hE471, 16'h3E86, 16'hFFF9, 16'h0C80};
		logic [15:0] v;
		foreach (vals[i]) begin
			send_temp(vals[i]);
			cyc(300);
			rd(PTR_TEMP, v);
			check(v, exps[i]);
		end
	endtask
	// hysteresis is 7 degrees here, so 25 degrees lies inside both clear bands
	task automatic scen_alarm();
		logic [15:0] v;
		wr_cfg(8'h0C);
		cyc(10);
		check(pinView, 16'h0000);
		send_temp(13'h07D0);
		cyc(300);
		check(pinView, 16'h0003);
		send_temp(13'h0190);
		cyc(300);
		check(pinView, 16'h0000);
		wr_cfg(8'h1C);
		send_temp(13'h07D0);
		cyc(450);
		check(pinView, 16'h0000);
		cyc(600);
		check(pinView, 16'h0003);
		wr_cfg(8'h1D);
		send_temp(13'h0190);
		cyc(1000);
		check(pinView, 16'h0003);
		wr(PTR_TEMP, 16'h1234);
		rd(PTR_TEMP, v);
		check(v, 16'h3E86);
		wr_cfg(8'h0C);
		send_temp(13'h0190);
		cyc(1000);
		check(pinView, 16'h0000);
		wr_cfg(8'h0E);
		send_temp(13'h07D0);
		cyc(300);
		check(pinView, 16'h0003);
		rd(PTR_CFG, v);
		check(v, 16'h0E0E);
		cyc(600);
		check(pinView, 16'h0001);
	endtask
	// scl stalled past the timeout: kept frame with bit 5 set, dropped frame without
	task automatic scen_timeout();
		logic nak;
		wr_cfg(8'h20);
		u_tmon_i2c_master_model.stall_ptr(DEV_ADDR, PTR_CFG, 6000, nak);
		check({15'h0000, nak}, 16'h0000);
		wr_cfg(8'h00);
		u_tmon_i2c_master_model.stall_ptr(DEV_ADDR, PTR_CFG, 6000, nak);
		check({15'h0000, nak}, 16'h0001);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1;
		adcSample = '0;
		straps = 4'hA;
		// long enough for the converter-side synchroniser too
		repeat (3) @(posedge adc_clk);
		@(posedge ref_clk);
		#1;
		reset = 1'b0;
		cyc(3);
		scen_reset();
		scen_bus();
		scen_encode();
		scen_alarm();
		scen_timeout();
		give_verdict();
	end
	initial begin
		cyc(100000);
		errors++;
		give_verdict();
	end
endmodule
